// *** shared/pcb_pkg.sv ***
// Package: constants for the card memory window bridge
package pcb_pkg;
    localparam int NUM_SLOTS = 2;
    localparam int NUM_WINS  = 5;
    localparam int SYS_AW    = 24;
    localparam int CARD_AW   = 26;
    localparam int PAGE_LSB  = 12;
    localparam int WAIT_W    = 2;
    localparam int SLOT_SPAN = 64;
    localparam int NUM_REGS  = 128;
    // Per-slot register offsets
    localparam logic [5:0] OFF_PWR    = 6'h02;
    localparam logic [5:0] OFF_IGC    = 6'h03;
    localparam logic [5:0] OFF_WIN_EN = 6'h06;
    localparam logic [5:0] OFF_VOLT   = 6'h17;
    localparam logic [5:0] OFF_WIN0   = 6'h10;
    localparam logic [5:0] WIN_STRIDE = 6'h08;
    // Byte positions inside one window block
    localparam int WB_STA_LO = 0;
    localparam int WB_STA_HI = 1;
    localparam int WB_STP_LO = 2;
    localparam int WB_STP_HI = 3;
    localparam int WB_OFF_LO = 4;
    localparam int WB_OFF_HI = 5;
    localparam int WB_COUNT  = 6;
    // Field positions
    localparam int STA_HI_WIDE = 7;
    localparam int STA_HI_ZWS  = 6;
    localparam int STA_HI_WAIT = 4;
    localparam int ADDR_HI_MSB = 3;
    localparam int OFF_HI_ATTR = 6;
    localparam int OFF_HI_MSB  = 5;
    localparam int IGC_MEM     = 5;
    localparam int SEL_LO      = 0;
    localparam int SEL_HI      = 1;
    // Host I/O ports and reset values
    localparam logic [15:0] IO_INDEX_PORT = 16'h03e0;
    localparam logic [15:0] IO_DATA_PORT  = 16'h03e1;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACC  = 3'b010,
        ST_HOLD = 3'b100
    } pcb_state_t;
endpackage : pcb_pkg

// *** hw/pcb_bridge.sv ***
// Module: host bus to two-slot card memory window bridge
`timescale 1ns/1ps
module pcb_bridge (
    input  wire logic                         CLOCK_IN,
    input  wire logic                         ARST_N_IN,
    input  wire logic [pcb_pkg::SYS_AW-1:0]   SA_IN,
    input  wire logic                         SBHE_N_IN,
    input  wire logic                         MEMR_N_IN,
    input  wire logic                         MEMW_N_IN,
    input  wire logic                         IOR_N_IN,
    input  wire logic                         IOW_N_IN,
    input  wire logic                         AEN_IN,
    input  wire logic [7:0]                   SD_IN,
    input  wire logic [pcb_pkg::NUM_SLOTS-1:0] CARD_WAIT_N_IN,
    output logic      [7:0]                   SD_OUT,
    output logic                              SD_OE_N_OUT,
    output logic                              HOST_READY_OUT,
    output logic                              ZERO_WAIT_OUT,
    output logic      [pcb_pkg::CARD_AW-1:0]  CARD_ADDR_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_CE1_N_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_CE2_N_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_REG_N_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_OE_N_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_WE_N_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_SUPPLY_SEL_LO_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] CARD_SUPPLY_SEL_HI_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] PROG_VOLT_SEL_LO_OUT,
    output logic [pcb_pkg::NUM_SLOTS-1:0] PROG_VOLT_SEL_HI_OUT
);
    import pcb_pkg::*;

    localparam int SW = SYS_AW + 16;
    localparam logic [NUM_SLOTS-1:0] ALL_HI = '1;

    // ==========================================================
    // Input synchronisers
    // All pins are async to the bus clock; two flop stages, read from the second
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {SA_IN, SBHE_N_IN, MEMR_N_IN, MEMW_N_IN,
                         IOR_N_IN, IOW_N_IN, AEN_IN, SD_IN,
                         CARD_WAIT_N_IN};
            sync2_ff <= sync1_ff;
        end
    end

    logic [SYS_AW-1:0]    s_addr;
    logic                 s_sbhe_n;
    logic                 s_memr_n;
    logic                 s_memw_n;
    logic                 s_ior_n;
    logic                 s_iow_n;
    logic                 s_aen;
    logic [7:0]           s_sd;
    logic [NUM_SLOTS-1:0] s_wait_n;

    assign s_addr   = sync2_ff[SW-1 -: SYS_AW];
    assign s_sbhe_n = sync2_ff[15];
    assign s_memr_n = sync2_ff[14];
    assign s_memw_n = sync2_ff[13];
    assign s_ior_n  = sync2_ff[12];
    assign s_iow_n  = sync2_ff[11];
    assign s_aen    = sync2_ff[10];
    assign s_sd     = sync2_ff[9:2];
    assign s_wait_n = sync2_ff[1:0];

    // ==========================================================
    // Register file
    logic [7:0]  regs_ff [NUM_REGS];
    logic [7:0]  nxt_regs [NUM_REGS];
    logic [7:0]  idx_ff, nxt_idx;
    logic [15:0] lat_io_ff, nxt_lat_io;
    logic [7:0]  lat_data_ff, nxt_lat_data;
    logic        lat_ok_ff, nxt_lat_ok;
    logic        iow_d_ff, nxt_iow_d;
    logic [7:0]  sd_out_ff, nxt_sd_out;
    logic        sd_oe_n_ff, nxt_sd_oe_n;
    logic [NUM_SLOTS-1:0] sup_lo_ff, sup_hi_ff, vpp_lo_ff, vpp_hi_ff;
    logic [NUM_SLOTS-1:0] nxt_sup_lo, nxt_sup_hi;
    logic [NUM_SLOTS-1:0] nxt_vpp_lo, nxt_vpp_hi;
    logic        io_wr_end;
    logic        rd_hit;

    function automatic logic is_mapped(input logic [7:0] i);
        logic [5:0] o;
        int         w;
        o = i[5:0];
        w = int'(o) - int'(OFF_WIN0);
        // Indices 80h and up belong to a second chip, never aliased
        return !i[7] && ((o == OFF_PWR) || (o == OFF_IGC) ||
               (o == OFF_WIN_EN) || (o == OFF_VOLT) || (w >= 0 &&
               w < NUM_WINS * int'(WIN_STRIDE) &&
               (w % int'(WIN_STRIDE)) < WB_COUNT));
    endfunction : is_mapped

    function automatic logic [7:0] rg(input int s, input logic [5:0] o);
        return regs_ff[s * SLOT_SPAN + int'(o)];
    endfunction : rg

    function automatic logic [7:0] wb(input int s, input int w,
                                      input int b);
        return regs_ff[s * SLOT_SPAN + int'(OFF_WIN0) +
                       w * int'(WIN_STRIDE) + b];
    endfunction : wb

    // Address is taken while the strobe is low, written on release
    assign io_wr_end = !iow_d_ff && s_iow_n && lat_ok_ff;
    assign rd_hit    = !s_ior_n && !s_aen &&
                       (s_addr[15:1] == IO_INDEX_PORT[15:1]);

    always_comb begin
        nxt_regs     = regs_ff;
        nxt_idx      = idx_ff;
        nxt_iow_d    = s_iow_n;
        nxt_lat_io   = lat_io_ff;
        nxt_lat_data = lat_data_ff;
        nxt_lat_ok   = lat_ok_ff;
        if (!s_iow_n) begin
            nxt_lat_io   = s_addr[15:0];
            nxt_lat_data = s_sd;
            nxt_lat_ok   = !s_aen;
        end
        if (io_wr_end) begin
            nxt_lat_ok = 1'b0;
            if (lat_io_ff == IO_INDEX_PORT) begin
                nxt_idx = lat_data_ff;
            end else if (lat_io_ff == IO_DATA_PORT &&
                         is_mapped(idx_ff)) begin
                nxt_regs[idx_ff[6:0]] = lat_data_ff;
            end
        end
        nxt_sd_oe_n = !rd_hit;
        nxt_sd_out  = 8'h00;
        if (rd_hit) begin
            if (s_addr[0] == IO_INDEX_PORT[0]) begin
                nxt_sd_out = idx_ff;
            end else if (is_mapped(idx_ff)) begin
                nxt_sd_out = regs_ff[idx_ff[6:0]];
            end
        end
        for (int s = 0; s < NUM_SLOTS; s++) begin
            nxt_sup_lo[s] = regs_ff[s * SLOT_SPAN + int'(OFF_VOLT)][SEL_LO];
            nxt_sup_hi[s] = regs_ff[s * SLOT_SPAN + int'(OFF_VOLT)][SEL_HI];
            nxt_vpp_lo[s] = regs_ff[s * SLOT_SPAN + int'(OFF_PWR)][SEL_LO];
            nxt_vpp_hi[s] = regs_ff[s * SLOT_SPAN + int'(OFF_PWR)][SEL_HI];
        end
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= REG_RESET;
            end
            idx_ff      <= 8'h00;
            lat_io_ff   <= 16'h0000;
            lat_data_ff <= 8'h00;
            lat_ok_ff   <= 1'b0;
            iow_d_ff    <= 1'b1;
            sd_out_ff   <= 8'h00;
            sd_oe_n_ff  <= 1'b1;
            sup_lo_ff   <= '0;
            sup_hi_ff   <= '0;
            vpp_lo_ff   <= '0;
            vpp_hi_ff   <= '0;
        end else begin
            regs_ff     <= nxt_regs;
            idx_ff      <= nxt_idx;
            lat_io_ff   <= nxt_lat_io;
            lat_data_ff <= nxt_lat_data;
            lat_ok_ff   <= nxt_lat_ok;
            iow_d_ff    <= nxt_iow_d;
            sd_out_ff   <= nxt_sd_out;
            sd_oe_n_ff  <= nxt_sd_oe_n;
            sup_lo_ff   <= nxt_sup_lo;
            sup_hi_ff   <= nxt_sup_hi;
            vpp_lo_ff   <= nxt_vpp_lo;
            vpp_hi_ff   <= nxt_vpp_hi;
        end
    end

    // ==========================================================
    // Window decode
    logic                    hit;
    logic [0:0]              hs;
    logic [13:0]             hpage;
    logic [7:0]              hsta_hi;
    logic                    hattr;

    // 12-bit page compare gives 4KB steps over 16MB
    always_comb begin
        logic [11:0] pg;
        logic [11:0] sta;
        logic [11:0] stp;
        logic [7:0]  oh;
        logic [7:0]  sh;
        logic [7:0]  ph;
        logic [7:0]  en;
        logic [7:0]  gc;
        pg      = s_addr[SYS_AW-1:PAGE_LSB];
        sta     = 12'h000;
        stp     = 12'h000;
        oh      = 8'h00;
        sh      = 8'h00;
        ph      = 8'h00;
        en      = 8'h00;
        gc      = 8'h00;
        hit     = 1'b0;
        hs      = 1'b0;
        hpage   = 14'h0000;
        hsta_hi = 8'h00;
        hattr   = 1'b0;
        // Lowest slot and window win; loops run downward
        for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
            for (int w = NUM_WINS - 1; w >= 0; w--) begin
                sh  = wb(s, w, WB_STA_HI);
                ph  = wb(s, w, WB_STP_HI);
                en  = rg(s, OFF_WIN_EN);
                gc  = rg(s, OFF_IGC);
                sta = {sh[ADDR_HI_MSB:0], wb(s, w, WB_STA_LO)};
                stp = {ph[ADDR_HI_MSB:0], wb(s, w, WB_STP_LO)};
                oh  = wb(s, w, WB_OFF_HI);
                if (en[w] && pg >= sta && pg <= stp) begin
                    hit     = 1'b1;
                    hs      = 1'(s);
                    // Card page is system page plus offset
                    hpage   = 14'(pg) + {oh[OFF_HI_MSB:0],
                                         wb(s, w, WB_OFF_LO)};
                    hsta_hi = sh;
                    hattr   = oh[OFF_HI_ATTR] & gc[IGC_MEM];
                end
            end
        end
    end

    // ==========================================================
    // Card cycle
    pcb_state_t           st_ff, nxt_st;
    logic [0:0]           slot_ff, nxt_slot;
    logic [WAIT_W-1:0]    cnt_ff, nxt_cnt;
    logic                 zws_ff, nxt_zws;
    logic                 wide_ff, nxt_wide;
    logic                 hbe_ff, nxt_hbe;
    logic                 ready_ff, nxt_ready;
    logic                 zw_ff, nxt_zw;
    logic [CARD_AW-1:0]   caddr_ff, nxt_caddr;
    logic [NUM_SLOTS-1:0] ce1_ff, ce2_ff, reg_ff, oe_ff, we_ff;
    logic [NUM_SLOTS-1:0] nxt_ce1, nxt_ce2, nxt_reg, nxt_oe, nxt_we;
    logic                 mem_cmd;

    assign mem_cmd = (!s_memr_n || !s_memw_n) && !s_aen;

    always_comb begin
        nxt_st    = st_ff;
        nxt_slot  = slot_ff;
        nxt_cnt   = cnt_ff;
        nxt_zws   = zws_ff;
        nxt_wide  = wide_ff;
        nxt_hbe   = hbe_ff;
        nxt_caddr = caddr_ff;
        nxt_ce1   = ce1_ff;
        nxt_ce2   = ce2_ff;
        nxt_reg   = reg_ff;
        nxt_oe    = oe_ff;
        nxt_we    = we_ff;
        case (st_ff)
            ST_IDLE: begin
                // No card strobe without a window hit
                if (mem_cmd && hit) begin
                    nxt_st    = ST_ACC;
                    nxt_slot  = hs;
                    // 26-bit card address, 64M per region
                    nxt_caddr = {hpage, s_addr[PAGE_LSB-1:0]};
                    nxt_wide  = hsta_hi[STA_HI_WIDE];
                    // SBHE low marks a 16-bit host cycle
                    nxt_hbe   = !s_sbhe_n;
                    nxt_zws   = hsta_hi[STA_HI_ZWS];
                    // Extra waits from start high byte
                    nxt_cnt   = hsta_hi[STA_HI_ZWS] ? '0 :
                        hsta_hi[STA_HI_WAIT +: WAIT_W];
                    nxt_ce1   = ALL_HI;
                    nxt_ce2   = ALL_HI;
                    // Enables from width bit, SBHE and A0
                    if (hsta_hi[STA_HI_WIDE] && !s_sbhe_n) begin
                        nxt_ce1[hs] = 1'b0;
                        nxt_ce2[hs] = 1'b0;
                    end else if (hsta_hi[STA_HI_WIDE]) begin
                        nxt_ce1[hs] = s_addr[0];
                        nxt_ce2[hs] = !s_addr[0];
                    end else begin
                        nxt_ce1[hs] = 1'b0;
                    end
                    nxt_reg     = ALL_HI;
                    nxt_reg[hs] = !hattr;
                    nxt_oe      = ALL_HI;
                    nxt_we      = ALL_HI;
                    nxt_oe[hs]  = s_memr_n;
                    nxt_we[hs]  = s_memw_n;
                end else if (mem_cmd) begin
                    // Miss: sit out this command, no late decode
                    nxt_st = ST_HOLD;
                end
            end
            ST_ACC: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
                if (!mem_cmd) begin
                    nxt_st  = ST_IDLE;
                    nxt_cnt = '0;
                    nxt_zws = 1'b0;
                    nxt_ce1 = ALL_HI;
                    nxt_ce2 = ALL_HI;
                    nxt_reg = ALL_HI;
                    nxt_oe  = ALL_HI;
                    nxt_we  = ALL_HI;
                end
            end
            ST_HOLD: begin
                if (!mem_cmd) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        // Card WAIT and counted waits hold ready low
        nxt_ready = !(nxt_st == ST_ACC &&
                      (nxt_cnt != '0 || !s_wait_n[nxt_slot]));
        nxt_zw    = (nxt_st == ST_ACC) && nxt_zws;
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_ff    <= ST_IDLE;
            slot_ff  <= 1'b0;
            cnt_ff   <= '0;
            zws_ff   <= 1'b0;
            wide_ff  <= 1'b0;
            hbe_ff   <= 1'b0;
            ready_ff <= 1'b1;
            zw_ff    <= 1'b0;
            caddr_ff <= '0;
            ce1_ff   <= '1;
            ce2_ff   <= '1;
            reg_ff   <= '1;
            oe_ff    <= '1;
            we_ff    <= '1;
        end else begin
            st_ff    <= nxt_st;
            slot_ff  <= nxt_slot;
            cnt_ff   <= nxt_cnt;
            zws_ff   <= nxt_zws;
            wide_ff  <= nxt_wide;
            hbe_ff   <= nxt_hbe;
            ready_ff <= nxt_ready;
            zw_ff    <= nxt_zw;
            caddr_ff <= nxt_caddr;
            ce1_ff   <= nxt_ce1;
            ce2_ff   <= nxt_ce2;
            reg_ff   <= nxt_reg;
            oe_ff    <= nxt_oe;
            we_ff    <= nxt_we;
        end
    end

    // Host side and two card slots driven from flops
    assign SD_OUT                 = sd_out_ff;
    assign SD_OE_N_OUT            = sd_oe_n_ff;
    assign HOST_READY_OUT         = ready_ff;
    assign ZERO_WAIT_OUT          = zw_ff;
    assign CARD_ADDR_OUT          = caddr_ff;
    assign CARD_CE1_N_OUT         = ce1_ff;
    assign CARD_CE2_N_OUT         = ce2_ff;
    assign CARD_REG_N_OUT         = reg_ff;
    assign CARD_OE_N_OUT          = oe_ff;
    assign CARD_WE_N_OUT          = we_ff;
    assign CARD_SUPPLY_SEL_LO_OUT = sup_lo_ff;
    assign CARD_SUPPLY_SEL_HI_OUT = sup_hi_ff;
    assign PROG_VOLT_SEL_LO_OUT   = vpp_lo_ff;
    assign PROG_VOLT_SEL_HI_OUT   = vpp_hi_ff;

    // ==========================================================
    // Assertions
    a_supply_follow: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        CARD_SUPPLY_SEL_HI_OUT[1] ==
            $past(regs_ff[SLOT_SPAN + int'(OFF_VOLT)][SEL_HI]))
        else $error("supply select does not track register");
    a_vpp_follow: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        PROG_VOLT_SEL_LO_OUT[0] == $past(regs_ff[int'(OFF_PWR)][SEL_LO]))
        else $error("vpp select does not track register");
    a_idle_no_ce: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff != ST_ACC |-> (&CARD_CE1_N_OUT) && (&CARD_CE2_N_OUT))
        else $error("card enabled outside a window hit");
    a_miss_stays: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff == ST_IDLE && mem_cmd && !hit |=> st_ff == ST_HOLD)
        else $error("access started without a hit");
    a_ce_wide_pair: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff == ST_ACC && wide_ff && hbe_ff |->
            !CARD_CE1_N_OUT[slot_ff] && !CARD_CE2_N_OUT[slot_ff])
        else $error("16-bit access lacks both enables");
    a_wait_ready: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff == ST_ACC && mem_cmd && !s_wait_n[slot_ff]
            |=> !HOST_READY_OUT)
        else $error("card wait did not stall host");
    a_extra_waits: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff == ST_ACC && cnt_ff != '0 |-> !HOST_READY_OUT)
        else $error("ready high during counted waits");
    a_zero_wait: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        st_ff == ST_ACC && zws_ff |-> ZERO_WAIT_OUT && cnt_ff == '0)
        else $error("zero-wait window not reported");
    a_index_write: assert property (@(posedge CLOCK_IN)
        disable iff (!ARST_N_IN)
        io_wr_end && lat_io_ff == IO_INDEX_PORT
            |=> idx_ff == $past(lat_data_ff))
        else $error("index port write lost");
endmodule : pcb_bridge

// *** test/pcb_card_model.sv ***
// Card model: memory card that stretches accesses with its WAIT line
`timescale 1ns/1ps
module pcb_card_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] ce1_n_in,
    input  wire logic [1:0] ce2_n_in,
    input  wire logic [7:0] wait_len_in,
    output logic      [1:0] wait_n_out
);
    int cnt [2];
    // =========================================================
    // Access length counter
    // Falling edge, so WAIT moves away from the bridge's sampling edge
    always @(negedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            if (!rst_n_in || (ce1_n_in[s] && ce2_n_in[s])) cnt[s] <= 0;
            else if (cnt[s] < 255) cnt[s] <= cnt[s] + 1;
        end
    end
    // WAIT held low for the programmed length
    // Pulled up once the card is deselected
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            wait_n_out[s] = !(cnt[s] >= 1 && cnt[s] <= int'(wait_len_in));
        end
    end
endmodule : pcb_card_model

// *** test/tb.sv ***
// Testbench: register and memory window scenarios for the bridge
`timescale 1ns/1ps
module tb;
    import pcb_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [SYS_AW-1:0] sa = '0;
    logic              sbhe_n = 1'b1, memr_n = 1'b1, memw_n = 1'b1;
    logic              ior_n = 1'b1, iow_n = 1'b1, aen = 1'b0;
    logic [7:0]        sd = 8'h00, r, wait_len = 8'h00;
    logic [7:0]        sd_out;
    logic              sd_oe_n, rdy, zw;
    logic [CARD_AW-1:0] addr;
    logic [1:0]        ce1, ce2, reg_n, oe, we, wait_n, vlo, vhi, plo, phi;
    logic [7:0]        win [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00};
    wire  [11:0]       pins = {oe, we, reg_n, ce2, ce1, zw, rdy};
    int                err_count = 0, check_count = 0, n;
    always #50 clk = ~clk;
    pcb_bridge pcb_bridge_inst (.CLOCK_IN(clk), .ARST_N_IN(rst_n),
        .SA_IN(sa), .SBHE_N_IN(sbhe_n), .MEMR_N_IN(memr_n),
        .MEMW_N_IN(memw_n), .IOR_N_IN(ior_n), .IOW_N_IN(iow_n),
        .AEN_IN(aen), .SD_IN(sd), .CARD_WAIT_N_IN(wait_n),
        .SD_OUT(sd_out), .SD_OE_N_OUT(sd_oe_n), .HOST_READY_OUT(rdy),
        .ZERO_WAIT_OUT(zw), .CARD_ADDR_OUT(addr), .CARD_CE1_N_OUT(ce1),
        .CARD_CE2_N_OUT(ce2), .CARD_REG_N_OUT(reg_n), .CARD_OE_N_OUT(oe),
        .CARD_WE_N_OUT(we), .CARD_SUPPLY_SEL_LO_OUT(vlo),
        .CARD_SUPPLY_SEL_HI_OUT(vhi), .PROG_VOLT_SEL_LO_OUT(plo),
        .PROG_VOLT_SEL_HI_OUT(phi));
    pcb_card_model pcb_card_model_inst (
        .clk_in(clk), .rst_n_in(rst_n), .ce1_n_in(ce1), .ce2_n_in(ce2),
        .wait_len_in(wait_len), .wait_n_out(wait_n));
    // =========================================================
    // Compare and report
    task automatic chk_d(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : chk_d
    task automatic chk_p(input logic [25:0] got, input logic [25:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask : chk_p
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // =========================================================
    // Host I/O cycles, strobes held four clocks to clear the sync stage
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        sa = {8'h00, a};
        sd = d;
        iow_n = 1'b0;
        repeat (4) @(negedge clk);
        iow_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : io_wr
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        sa = {8'h00, a};
        ior_n = 1'b0;
        repeat (4) @(negedge clk);
        d = sd_oe_n ? 8'hxx : sd_out;
        ior_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask : io_rd
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        io_wr(IO_INDEX_PORT, idx);
        io_wr(IO_DATA_PORT, d);
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        io_wr(IO_INDEX_PORT, idx);
        io_rd(IO_DATA_PORT, got);
        chk_d(got, exp);
    endtask : reg_chk
    // Memory cycle: outputs settle three edges after the strobe
    task automatic mem_go(input logic [23:0] a, input logic hb,
                          input logic wr);
        @(negedge clk);
        sa = a;
        sbhe_n = hb;
        if (wr) memw_n = 1'b0;
        else memr_n = 1'b0;
        repeat (3) @(negedge clk);
    endtask : mem_go
    task automatic mem_end;
        memr_n = 1'b1;
        memw_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : mem_end
    // =========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk_p(pins, 26'hffd);
        reg_chk(8'(OFF_VOLT), REG_RESET);
        $display("test reset done");
        reg_wr(8'h17, 8'h03);
        reg_wr(8'h57, 8'h02);
        reg_wr(8'h02, 8'h01);
        reg_wr(8'h42, 8'h02);
        io_rd(IO_INDEX_PORT, r);
        chk_d(r, 8'h42);
        reg_chk(8'h17, 8'h03);
        chk_p({18'h0, phi, plo, vhi, vlo}, 26'h9d);
        reg_chk(8'h57, 8'h02);
        reg_wr(8'h82, 8'h5a);
        reg_chk(8'h82, 8'h00);
        $display("test registers done");
        for (int i = 0; i < WB_COUNT; i++) reg_wr(8'(OFF_WIN0) + 8'(i), win[i]);
        reg_wr(8'(OFF_WIN_EN), 8'h01);
        mem_go(24'h001abc, 1'b1, 1'b0);
        chk_p(pins, 26'hbf9);
        chk_p(addr, 26'h003abc);
        mem_end;
        mem_go(24'h001ffe, 1'b1, 1'b1);
        chk_p(pins, 26'hef9);
        mem_end;
        mem_go(24'h002000, 1'b1, 1'b0);
        chk_p(pins, 26'hffd);
        mem_end;
        reg_wr(8'h11, 8'hc0);
        reg_wr(8'h15, 8'h40);
        reg_wr(8'(OFF_IGC), 8'h20);
        mem_go(24'h001abc, 1'b0, 1'b0);
        chk_p(pins, 26'hbab);
        mem_end;
        mem_go(24'h001abd, 1'b1, 1'b0);
        chk_p(pins, 26'hbaf);
        mem_end;
        reg_wr(8'(OFF_IGC), 8'h00);
        mem_go(24'h001abc, 1'b0, 1'b0);
        chk_p(pins, 26'hbeb);
        mem_end;
        reg_wr(8'(OFF_WIN_EN), 8'h00);
        mem_go(24'h001abc, 1'b1, 1'b0);
        chk_p(pins, 26'hffd);
        mem_end;
        $display("test windows done");
        reg_wr(8'h11, 8'h20);
        reg_wr(8'(OFF_WIN_EN), 8'h01);
        mem_go(24'h001abc, 1'b1, 1'b0);
        @(negedge clk);
        chk_p(pins, 26'hbf8);
        repeat (2) @(negedge clk);
        chk_p(pins, 26'hbf9);
        mem_end;
        // Card stretch outlasts the programmed waits
        wait_len = 8'h08;
        mem_go(24'h001abc, 1'b1, 1'b0);
        repeat (5) @(negedge clk);
        chk_p(pins, 26'hbf8);
        for (n = 0; n < 30 && rdy !== 1'b1; n++) @(negedge clk);
        if (n == 30) begin
            err_count++;
            $display("mismatch at %0t: ready never returned", $time);
            conclude;
        end
        chk_p(pins, 26'hbf9);
        mem_end;
        $display("test waits done");
        conclude;
    end
endmodule : tb
